// File: hw/wdt_pkg.sv
// Operation
// - Software option: disarmed after reset, armed by setting arm flag, then stays armed.
// - Count decrements once every 3072 clocks; timeout in 64 equal steps.
// - Armed and soft-reset bit zero starts a reset cycle, reset pin low ~500ns.
// - Writing soft-reset bit zero while armed resets the chip at once.
// - Bits 7..2 hold period reversed: bit 7 is LSB, bit 2 is MSB.
// - Disarmed: soft-reset bit is MSB of a 7-bit down-timer, no reset.
// - Hardware option forces arm flag (bit 0) to one; writes cannot change it.
// - Arm flag zero is disarmed, one armed; software option clears only by reset.
// - Register at 0D8h, read/write, reset value FEh.
// - WAIT leaves the watchdog counting and able to reset.
// - Armed without external stop control: STOP executes as WAIT.
// - Armed with external stop control: NMI low gives WAIT, high freezes and stops.
// - Leaving STOP by interrupt, counting resumes from the frozen value.
// - Disarmed: STOP is entered normally.
// - Hardware option: permanently armed after reset; arm flag always reads 1.
`default_nettype none
package wdt_pkg;
  localparam logic [7:0] wdt_reg_offset   = 8'hd8;
  localparam logic [7:0] wdt_reg_reset    = 8'hfe;
  localparam int         wdt_arm_bit      = 0;
  localparam int         wdt_sr_bit       = 1;
  localparam int         wdt_step_cycles  = 3072;
  localparam int         wdt_clock_mhz    = 40;
  localparam int         wdt_pulse_ns     = 500;
  localparam int         wdt_pulse_cycles = (wdt_pulse_ns * wdt_clock_mhz) / 1000;
  localparam int         wdt_addr_width   = 8;

  typedef struct packed {
    logic [wdt_addr_width-1:0] address;
    logic                      read;
    logic                      write;
    logic [31:0]               writedata;
  } wdt_bus_req_type;

  typedef struct packed {
    logic [31:0] readdata;
    logic        waitrequest;
  } wdt_bus_rsp_type;

  typedef enum logic [1:0] {
    wdt_pm_run,
    wdt_pm_wait,
    wdt_pm_stop
  } wdt_power_type;
endpackage
`default_nettype wire

// File: hw/wdt_prescaler.sv
`default_nettype none
module wdt_prescaler #(
  parameter int steps = wdt_pkg::wdt_step_cycles
) (
  // Clock and reset
  input  wire logic clock,
  input  wire logic rst,
  // Control
  input  wire logic run,
  input  wire logic restart,
  // Tick
  output logic      tick
);
  typedef struct packed {
    logic [11:0] cnt;
    logic        tick;
  } wdt_pre_state_type;

  wdt_pre_state_type state_reg;
  wdt_pre_state_type state_next;

  always_comb
  begin
    state_next      = state_reg;
    state_next.tick = 1'b0;
    if (restart)
      state_next.cnt = 12'h000;
    else if (run)
    begin
      if (state_reg.cnt == 12'(steps - 1))
      begin
        state_next.cnt  = 12'h000;
        state_next.tick = 1'b1;
      end
      else
        state_next.cnt = state_reg.cnt + 12'h001;
    end
  end

  always_ff @(posedge clock)
  begin
    if (rst)
      state_reg <= '0;
    else
      state_reg <= state_next;
  end

  assign tick = state_reg.tick;

  tick_period_a: assert property (@(posedge clock) disable iff (rst)
    tick |-> $past(run) && state_reg.cnt == 12'h000)
    else $error("tick without a completed interval");
endmodule
`default_nettype wire

// File: hw/wdt_watchdog.sv
// Chosen here: the Avalon-MM slave port.
`default_nettype none
module wdt_watchdog #(
  parameter int pulse_cycles = wdt_pkg::wdt_pulse_cycles
) (
  // Clock and reset
  input  wire logic                     clock,
  input  wire logic                     rst,
  // Option straps
  input  wire logic                     activation_option,
  input  wire logic                     ext_stop_option,
  // Core power control
  input  wire logic                     stop_request,
  input  wire logic                     wait_request,
  input  wire logic                     wake_interrupt,
  input  wire logic                     nmi_pin,
  output logic                          core_stopped,
  output logic                          core_waiting,
  // Reset output, open drain
  output logic                          chip_reset_out,
  output logic                          chip_reset_oe_n,
  // Register bus
  input  wire wdt_pkg::wdt_bus_req_type bus_req,
  output wdt_pkg::wdt_bus_rsp_type      bus_rsp
);
  typedef struct packed {
    logic [6:0]                 count;
    logic                       armed;
    logic                       hw_opt;
    logic                       ext_opt;
    logic [7:0]                 pulse;
    wdt_pkg::wdt_power_type     pm;
    logic [31:0]                rdata;
    logic                       rvalid;
    logic                       nmi_meta;
    logic                       nmi_sync;
    logic                       strap_done;
  } wdt_state_type;

  wdt_state_type state_reg;
  wdt_state_type state_next;
  logic          tick;
  logic          hit;
  logic          wr;
  logic          rd;
  logic          counting;
  logic [7:0]    reg_view;
  logic [6:0]    wcount;

  assign hit = bus_req.address == wdt_pkg::wdt_reg_offset;
  assign wr  = bus_req.write && state_reg.pulse == 8'h00;
  assign rd  = bus_req.read && !state_reg.rvalid;
  // Frozen only in a real STOP; WAIT keeps counting
  assign counting = state_reg.pm != wdt_pkg::wdt_pm_stop;

  // Reversed period field; physical count is {sr, t5..t0}
  always_comb
  begin
    reg_view = '0;
    for (int i = 0; i < 6; i++)
      reg_view[7 - i] = state_reg.count[i];
    reg_view[wdt_pkg::wdt_sr_bit]  = state_reg.count[6];
    reg_view[wdt_pkg::wdt_arm_bit] = state_reg.armed;
    wcount = '0;
    for (int i = 0; i < 6; i++)
      wcount[i] = bus_req.writedata[7 - i];
    wcount[6] = bus_req.writedata[wdt_pkg::wdt_sr_bit];
  end

  wdt_prescaler u_pre (
    .clock   (clock),
    .rst     (rst),
    .run     (counting),
    .restart (wr && hit),
    .tick    (tick)
  );

  always_comb
  begin
    state_next          = state_reg;
    state_next.nmi_meta = nmi_pin;
    state_next.nmi_sync = state_reg.nmi_meta;
    state_next.rvalid   = 1'b0;
    if (!state_reg.strap_done)
    begin
      // Straps sampled once after reset release
      state_next.strap_done = 1'b1;
      state_next.hw_opt     = activation_option;
      state_next.ext_opt    = ext_stop_option;
      state_next.armed      = activation_option;
    end
    if (state_reg.pulse != 8'h00)
      state_next.pulse = state_reg.pulse - 8'h01;
    if (wr && hit)
    begin
      state_next.count = wcount;
      if (!state_reg.hw_opt && bus_req.writedata[wdt_pkg::wdt_arm_bit])
        state_next.armed = 1'b1;
    end
    else if (tick)
      state_next.count = state_reg.count - 7'h01;
    // Armed and soft-reset bit low: reset cycle
    if (state_next.armed && !state_next.count[6] && state_reg.pulse == 8'h00)
      state_next.pulse = 8'(pulse_cycles);
    if (rd)
    begin
      state_next.rvalid = 1'b1;
      state_next.rdata  = hit ? {24'h000000, reg_view} : 32'h00000000;
    end
    case (state_reg.pm)
      wdt_pkg::wdt_pm_run:
        if (wait_request)
          state_next.pm = wdt_pkg::wdt_pm_wait;
        else if (stop_request)
        begin
          if (!state_reg.armed)
            state_next.pm = wdt_pkg::wdt_pm_stop;
          else if (state_reg.ext_opt && state_reg.nmi_sync)
            state_next.pm = wdt_pkg::wdt_pm_stop;
          else
            state_next.pm = wdt_pkg::wdt_pm_wait;
        end
      wdt_pkg::wdt_pm_wait,
      wdt_pkg::wdt_pm_stop:
        if (wake_interrupt)
          state_next.pm = wdt_pkg::wdt_pm_run;
      default:
        state_next.pm = wdt_pkg::wdt_pm_run;
    endcase
    if (state_reg.pulse != 8'h00)
      state_next.pm = wdt_pkg::wdt_pm_run;
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      state_reg       <= '0;
      state_reg.count <= 7'h7f;
    end
    else
      state_reg <= state_next;
  end

  // Reset pin pulled low while pulse runs; enable low means driving
  assign chip_reset_out      = 1'b0;
  assign chip_reset_oe_n     = state_reg.pulse == 8'h00;
  assign core_stopped        = state_reg.pm == wdt_pkg::wdt_pm_stop;
  assign core_waiting        = state_reg.pm == wdt_pkg::wdt_pm_wait;
  assign bus_rsp.readdata    = state_reg.rdata;
  // Writes stall during the reset pulse; reads stall for one cycle
  assign bus_rsp.waitrequest = (bus_req.read && !state_reg.rvalid)
                             || (bus_req.write && state_reg.pulse != 8'h00);

  reset_pulse_a: assert property (@(posedge clock) disable iff (rst)
    $rose(!chip_reset_oe_n) |-> !chip_reset_oe_n [*8])
    else $error("reset pulse too short");
  arm_sticky_a: assert property (@(posedge clock) disable iff (rst)
    state_reg.armed && state_reg.strap_done |=> state_reg.armed)
    else $error("arm flag cleared without reset");
  hw_armed_a: assert property (@(posedge clock) disable iff (rst)
    state_reg.strap_done && state_reg.hw_opt |-> state_reg.armed)
    else $error("hardware option not armed");
  sw_reset_a: assert property (@(posedge clock) disable iff (rst)
    wr && hit && state_reg.armed && !bus_req.writedata[1] |=> !chip_reset_oe_n)
    else $error("soft reset write ignored");
  disarmed_nores_a: assert property (@(posedge clock) disable iff (rst)
    !state_reg.armed && state_reg.strap_done && state_reg.pulse == 8'h00
    && !(wr && hit && bus_req.writedata[0]) |=> chip_reset_oe_n)
    else $error("reset while disarmed");
  stop_as_wait_a: assert property (@(posedge clock) disable iff (rst)
    state_reg.pm == wdt_pkg::wdt_pm_run && stop_request && !wait_request
    && state_reg.armed && !state_reg.ext_opt && chip_reset_oe_n
    |=> core_waiting)
    else $error("armed stop not taken as wait");
  frozen_stop_a: assert property (@(posedge clock) disable iff (rst)
    core_stopped && $past(core_stopped) && !$past(wr) |-> $stable(state_reg.count))
    else $error("count moved in stop");
  write_load_a: assert property (@(posedge clock) disable iff (rst)
    wr && hit |=> state_reg.count[5:0] == {$past(bus_req.writedata[2]),
    $past(bus_req.writedata[3]), $past(bus_req.writedata[4]),
    $past(bus_req.writedata[5]), $past(bus_req.writedata[6]),
    $past(bus_req.writedata[7])})
    else $error("write did not load count");
  read_back_a: assert property (@(posedge clock) disable iff (rst)
    rd && hit |=> bus_rsp.readdata[7:0] == $past(reg_view))
    else $error("read data differs from register");
  pulse_wait_a: assert property (@(posedge clock) disable iff (rst)
    bus_req.write && state_reg.pulse != 8'h00 |-> bus_rsp.waitrequest)
    else $error("write accepted during reset pulse");

  cov_sw_reset_c:  cover property (@(posedge clock) $fell(chip_reset_oe_n));
  cov_stop_c:      cover property (@(posedge clock) $rose(core_stopped));
  cov_wait_c:      cover property (@(posedge clock) $rose(core_waiting));
  cov_tick_c:      cover property (@(posedge clock) tick && !state_reg.armed);
endmodule
`default_nettype wire

// File: tb/tb.sv
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic                     clock = 1'b0;
  logic                     rst = 1'b1;
  logic                     activation_option = 1'b0;
  logic                     ext_stop_option = 1'b0;
  logic                     stop_req = 1'b0;
  logic                     wait_req = 1'b0;
  logic                     wake = 1'b0;
  logic                     nmi = 1'b0;
  logic                     stopped;
  logic                     waiting;
  logic                     rst_out;
  logic                     rst_oe_n;
  wdt_pkg::wdt_bus_req_type req = '0;
  wdt_pkg::wdt_bus_rsp_type rsp;
  int                       failures = 0;
  int                       n_checks = 0;
  logic [7:0]               q;
  int                       n;

  wdt_watchdog u_wdt_watchdog (
    .clock             (clock),
    .rst               (rst),
    .activation_option (activation_option),
    .ext_stop_option   (ext_stop_option),
    .stop_request      (stop_req),
    .wait_request      (wait_req),
    .wake_interrupt    (wake),
    .nmi_pin           (nmi),
    .core_stopped      (stopped),
    .core_waiting      (waiting),
    .chip_reset_out    (rst_out),
    .chip_reset_oe_n   (rst_oe_n),
    .bus_req           (req),
    .bus_rsp           (rsp)
  );

  initial
    forever #12.5 clock = ~clock;

  task automatic finish_test();
    if (failures == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("mismatch %0t register %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_pin(input logic got, input logic exp);
    n_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("mismatch %0t flag %b expected %b", $time, got, exp);
    end
  endtask

  // Register byte from count and arm flag, count bits reversed
  function automatic logic [7:0] enc(input logic [6:0] c, input logic arm);
    logic [7:0] r;
    for (int i = 0; i < 6; i++)
      r[7-i] = c[i];
    r[1] = c[6];
    r[0] = arm;
    return r;
  endfunction

  // Waitrequest looked at mid-cycle, so the edge after is the taking edge
  task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d,
                     output logic [7:0] r);
    int k;
    k = 0;
    @(posedge clock);
    req <= '{address: a, read: ~wr, write: wr, writedata: {24'h0, d}};
    do
    begin
      @(negedge clock);
      k++;
    end
    while (rsp.waitrequest !== 1'b0 && k < 100);
    r = rsp.readdata[7:0];
    @(posedge clock);
    req.read <= 1'b0;
    req.write <= 1'b0;
    if (k >= 100)
    begin
      failures++;
      $display("mismatch %0t bus request never answered", $time);
    end
  endtask

  task automatic power(input int kind, input logic es, input logic ew);
    @(posedge clock);
    stop_req <= (kind == 0);
    wait_req <= (kind == 1);
    wake <= (kind == 2);
    @(posedge clock);
    stop_req <= 1'b0;
    wait_req <= 1'b0;
    wake <= 1'b0;
    @(negedge clock);
    chk_pin(stopped, es);
    chk_pin(waiting, ew);
  endtask

  task automatic wait_low(input int lim, output int k);
    k = 0;
    while (rst_oe_n !== 1'b0 && k < lim)
    begin
      @(negedge clock);
      k++;
    end
  endtask

  // Straps are only sampled right after release
  task automatic do_reset(input logic hw, input logic ext);
    @(posedge clock);
    rst <= 1'b1;
    activation_option <= hw;
    ext_stop_option <= ext;
    repeat (4) @(posedge clock);
    rst <= 1'b0;
    repeat (2) @(posedge clock);
  endtask

  initial
  begin
    logic [6:0] c;
    void'($urandom(32'hdf6f12b5));
    do_reset(1'b0, 1'b0);
    bus(1'b0, 8'hd8, 8'h00, q);
    chk_reg(q, 8'hfe);
    bus(1'b1, 8'h17, 8'h55, q);
    bus(1'b0, 8'h17, 8'h00, q);
    chk_reg(q, 8'h00);
    bus(1'b0, 8'hd8, 8'h00, q);
    chk_reg(q, 8'hfe);
    repeat (6)
    begin
      c = {1'b1, 6'($urandom)};
      bus(1'b1, 8'hd8, enc(c, 1'b0), q);
      bus(1'b0, 8'hd8, 8'h00, q);
      chk_reg(q, enc(c, 1'b0));
    end
    bus(1'b1, 8'hd8, enc(7'h40, 1'b0), q);
    repeat (3030) @(posedge clock);
    bus(1'b0, 8'hd8, 8'h00, q);
    chk_reg(q, enc(7'h40, 1'b0));
    repeat (40) @(posedge clock);
    bus(1'b0, 8'hd8, 8'h00, q);
    chk_reg(q, enc(7'h3f, 1'b0));
    bus(1'b0, 8'hd8, 8'h00, q);
    chk_reg(q, enc(7'h3f, 1'b0));
    chk_pin(rst_oe_n, 1'b1);
    power(0, 1'b1, 1'b0);
    power(2, 1'b0, 1'b0);
    bus(1'b1, 8'hd8, enc(7'h41, 1'b1), q);
    bus(1'b0, 8'hd8, 8'h00, q);
    chk_reg(q, enc(7'h41, 1'b1));
    bus(1'b1, 8'hd8, enc(7'h41, 1'b0), q);
    bus(1'b0, 8'hd8, 8'h00, q);
    chk_reg(q, enc(7'h41, 1'b1));
    power(0, 1'b0, 1'b1);
    power(2, 1'b0, 1'b0);
    bus(1'b1, 8'hd8, enc(7'h40, 1'b1), q);
    power(1, 1'b0, 1'b1);
    wait_low(3120, n);
    chk_pin(n > 3050 && n < 3120, 1'b1);
    n = 0;
    while (rst_oe_n === 1'b0 && n < 100)
    begin
      @(negedge clock);
      n++;
    end
    chk_pin(n == 500 / 25, 1'b1);
    do_reset(1'b0, 1'b0);
    bus(1'b1, 8'hd8, 8'h01, q);
    wait_low(5, n);
    chk_pin(rst_oe_n, 1'b0);
    do_reset(1'b1, 1'b1);
    bus(1'b0, 8'hd8, 8'h00, q);
    chk_reg(q, 8'hff);
    bus(1'b1, 8'hd8, enc(7'h40, 1'b0), q);
    bus(1'b0, 8'hd8, 8'h00, q);
    chk_reg(q, enc(7'h40, 1'b1));
    power(0, 1'b0, 1'b1);
    power(2, 1'b0, 1'b0);
    @(posedge clock);
    nmi <= 1'b1;
    repeat (3) @(posedge clock);
    power(0, 1'b1, 1'b0);
    repeat (3200) @(posedge clock);
    chk_pin(rst_oe_n, 1'b1);
    power(2, 1'b0, 1'b0);
    wait_low(3100, n);
    chk_pin(n < 3066 && rst_oe_n === 1'b0, 1'b1);
    finish_test();
  end

  // Whole run needs about 12600 cycles
  initial
  begin
    repeat (30000) @(posedge clock);
    failures++;
    $display("mismatch %0t run did not finish in time", $time);
    finish_test();
  end
endmodule
`default_nettype wire
